// ===== include/slfc_pkg.sv
// Shared constants, types and helpers of the store-to-load forward check.
package slfc_pkg;

  // ----------------------------------------------------------------------
  // Widths and geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W     = 32;   // Byte address width.
  localparam int DATA_W     = 64;   // Widest operand, one quadword.
  localparam int SB_DEPTH   = 8;    // Store buffer entries, power of two.
  localparam int LINE_BYTES = 64;   // Cache line size in bytes.
  localparam int LINE_OFS_W = $clog2(LINE_BYTES);
  localparam int ALIAS_W    = 12;   // Address bits seen by the quick check.

  // ----------------------------------------------------------------------
  // Operand sizes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SZ_BYTE  = 2'b00,
    SZ_WORD  = 2'b01,
    SZ_DWORD = 2'b10,
    SZ_QWORD = 2'b11
  } slfc_size_t;

  // Load state machine.
  typedef enum logic [1:0] {
    LD_IDLE  = 2'b00,
    LD_CHECK = 2'b01,
    LD_HOLD  = 2'b10
  } slfc_ld_state_t;

  // Number of bytes an operand of the given size spans.
  function automatic logic [3:0] size_bytes(input slfc_size_t s);
    size_bytes = 4'h1 << s;
  endfunction

  // An access is misaligned when its address is not a multiple of its size.
  function automatic logic misaligned(input logic [ADDR_W-1:0] a,
                                      input slfc_size_t s);
    logic [3:0] low_mask;
    low_mask   = size_bytes(s) - 4'h1;
    misaligned = (a[3:0] & low_mask) != 4'h0;
  endfunction

  // Byte-range overlap on the low address bits only, so aliases also hit.
  function automatic logic alias_overlap(input logic [ADDR_W-1:0] a,
                                         input slfc_size_t sa,
                                         input logic [ADDR_W-1:0] b,
                                         input slfc_size_t sb);
    logic [ALIAS_W:0] a_lo;
    logic [ALIAS_W:0] b_lo;
    a_lo = {1'b0, a[ALIAS_W-1:0]};
    b_lo = {1'b0, b[ALIAS_W-1:0]};
    alias_overlap = (a_lo < b_lo + (ALIAS_W+1)'(size_bytes(sb))) &&
                    (b_lo < a_lo + (ALIAS_W+1)'(size_bytes(sa)));
  endfunction

  // Cache line index of a byte address.
  function automatic logic [ADDR_W-LINE_OFS_W-1:0] line_of(
      input logic [ADDR_W-1:0] a);
    line_of = a[ADDR_W-1:LINE_OFS_W];
  endfunction

endpackage

// ===== include/slfc_chk_if.sv
// Carrier between the store buffer and the forwarding eligibility check.
`timescale 1ns/1ps
interface slfc_chk_if;
  logic [slfc_pkg::ADDR_W-1:0] ld_addr;   // Load start address.
  slfc_pkg::slfc_size_t        ld_sz;     // Load operand size.
  logic [slfc_pkg::ADDR_W-1:0] st_addr;   // Candidate store address.
  slfc_pkg::slfc_size_t        st_sz;     // Candidate store size.
  logic                        st_hib;    // Store data from a high byte.
  logic [slfc_pkg::DATA_W-1:0] st_data;   // Candidate store data.
  logic                        fwd_ok;    // Store may feed the load.
  logic [slfc_pkg::DATA_W-1:0] fwd_data;  // Data cut to the load width.

  modport buf_side  (output ld_addr, ld_sz, st_addr, st_sz, st_hib, st_data,
                     input  fwd_ok, fwd_data);
  modport elig_side (input  ld_addr, ld_sz, st_addr, st_sz, st_hib, st_data,
                     output fwd_ok, fwd_data);
endinterface

// ===== design/slfc_elig.sv
// Forwarding eligibility of one store buffer entry for one load.
`timescale 1ns/1ps
module slfc_elig (
  input  wire logic sys_clk,          // Core clock, used by checks only.
  input  wire logic nrst,             // Synchronous reset, active low.
  slfc_chk_if.elig_side chk           // Load and candidate store.
);

  // ----------------------------------------------------------------------
  // Eligibility
  // ----------------------------------------------------------------------
  logic same_start;
  logic width_ok;
  logic any_misal;

  // Only an exact size match, or the low half of a quadword, may forward.
  always_comb begin
    same_start = chk.ld_addr == chk.st_addr;
    width_ok   = (chk.ld_sz == chk.st_sz) ||
                 (chk.st_sz == slfc_pkg::SZ_QWORD &&
                  chk.ld_sz == slfc_pkg::SZ_DWORD);
    any_misal  = slfc_pkg::misaligned(chk.ld_addr, chk.ld_sz) ||
                 slfc_pkg::misaligned(chk.st_addr, chk.st_sz);
    chk.fwd_ok = same_start && width_ok && !any_misal &&
                 !chk.st_hib;
  end

  // The load takes the low bytes of the store, masked to its own width.
  always_comb begin
    chk.fwd_data = chk.st_data &
                   ({slfc_pkg::DATA_W{1'b1}} >>
                    (slfc_pkg::DATA_W - 8 * int'(slfc_pkg::size_bytes(
                     chk.ld_sz))));
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_fwd_start_eq: assert property (@(posedge sys_clk) disable iff (!nrst)
    chk.fwd_ok |-> chk.ld_addr == chk.st_addr)
    else $error("Forward allowed with differing start addresses.");
  a_fwd_width: assert property (@(posedge sys_clk) disable iff (!nrst)
    chk.fwd_ok |-> chk.ld_sz <= chk.st_sz)
    else $error("Forward allowed to a wider load.");
  a_fwd_align: assert property (@(posedge sys_clk) disable iff (!nrst)
    chk.fwd_ok |-> chk.ld_addr[0] == 1'b0 || chk.ld_sz == slfc_pkg::SZ_BYTE)
    else $error("Forward allowed from a misaligned access.");
  a_fwd_hibyte: assert property (@(posedge sys_clk) disable iff (!nrst)
    chk.st_hib |-> !chk.fwd_ok)
    else $error("High-byte store allowed to forward.");

endmodule

// ===== design/slfc_fwd_top.sv
// Store buffer with store-to-load forward check and held-load tracking.
`timescale 1ns/1ps
module slfc_fwd_top #(
  parameter int SB_DEPTH = slfc_pkg::SB_DEPTH   // Store buffer entries.
) (
  input  wire logic                        sys_clk,     // Core clock.
  input  wire logic                        nrst,        // Sync reset, low.
  input  wire logic                        st_valid,    // Store to buffer.
  input  wire logic [slfc_pkg::ADDR_W-1:0] st_addr,     // Store address.
  input  wire slfc_pkg::slfc_size_t        st_sz,       // Store size.
  input  wire logic [slfc_pkg::DATA_W-1:0] st_data,     // Store data.
  input  wire logic                        st_hib,      // From high byte.
  output logic                             st_ready_q,  // Buffer has room.
  input  wire logic                        rob_st_retire, // Oldest store ok.
  output logic                             dc_wr_valid_q, // Cache write.
  output logic [slfc_pkg::ADDR_W-1:0]      dc_wr_addr_q,  // Write address.
  output slfc_pkg::slfc_size_t             dc_wr_sz_q,    // Write size.
  output logic [slfc_pkg::DATA_W-1:0]      dc_wr_data_q,  // Write data.
  input  wire logic                        dc_wr_ack,   // Cache took write.
  input  wire logic                        code_line_valid, // Line has code.
  input  wire logic [slfc_pkg::ADDR_W-slfc_pkg::LINE_OFS_W-1:0] code_line,
  output logic                             castout_q,   // Line cast out.
  output logic [slfc_pkg::ADDR_W-slfc_pkg::LINE_OFS_W-1:0] castout_line_q,
  input  wire logic                        ld_valid,    // Load request.
  input  wire logic [slfc_pkg::ADDR_W-1:0] ld_addr,     // Load address.
  input  wire slfc_pkg::slfc_size_t        ld_sz,       // Load size.
  output logic                             ld_ready_q,  // Can take a load.
  output logic                             ld_done_q,   // Load may write.
  output logic                             ld_fwd_q,    // Data forwarded.
  output logic [slfc_pkg::DATA_W-1:0]      ld_data_q,   // Forwarded data.
  output logic                             ld_held_q    // Load is held.
);

  localparam int PW = $clog2(SB_DEPTH);

  // ----------------------------------------------------------------------
  // Store buffer state
  // ----------------------------------------------------------------------
  logic [slfc_pkg::ADDR_W-1:0] sb_addr_q [SB_DEPTH];
  logic [slfc_pkg::ADDR_W-1:0] sb_addr_d [SB_DEPTH];
  slfc_pkg::slfc_size_t        sb_sz_q   [SB_DEPTH];
  slfc_pkg::slfc_size_t        sb_sz_d   [SB_DEPTH];
  logic [slfc_pkg::DATA_W-1:0] sb_data_q [SB_DEPTH];
  logic [slfc_pkg::DATA_W-1:0] sb_data_d [SB_DEPTH];
  logic [SB_DEPTH-1:0]         sb_hib_q, sb_hib_d;
  logic [SB_DEPTH-1:0]         sb_cmt_q, sb_cmt_d;
  logic [PW-1:0]               head_q, head_d, tail_q, tail_d;
  logic [PW-1:0]               cptr_q, cptr_d;
  logic [PW:0]                 cnt_q, cnt_d;
  logic                        push, pop;
  logic                        castout_d;
  logic [slfc_pkg::ADDR_W-slfc_pkg::LINE_OFS_W-1:0] castout_line_d;

  assign push = st_valid && st_ready_q;
  assign pop  = dc_wr_valid_q && dc_wr_ack;

  // Push, commit and drain. Entries leave strictly in program order, so a
  // held load only has to count pops up to its blocking store.
  always_comb begin
    sb_addr_d = sb_addr_q;
    sb_sz_d   = sb_sz_q;
    sb_data_d = sb_data_q;
    sb_hib_d  = sb_hib_q;
    sb_cmt_d  = sb_cmt_q;
    head_d    = head_q;
    tail_d    = tail_q;
    cptr_d    = cptr_q;
    cnt_d     = cnt_q;
    if (push) begin
      sb_addr_d[tail_q] = st_addr;
      sb_sz_d[tail_q]   = st_sz;
      sb_data_d[tail_q] = st_data;
      sb_hib_d[tail_q]  = st_hib;
      sb_cmt_d[tail_q]  = 1'b0;
      tail_d            = tail_q + PW'(1);
    end
    if (rob_st_retire) begin
      sb_cmt_d[cptr_q] = 1'b1;
      cptr_d           = cptr_q + PW'(1);
    end
    if (pop) begin
      head_d = head_q + PW'(1);
    end
    cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    // A write to a line that also holds code forces the other copy out.
    castout_d      = pop && code_line_valid &&
                     slfc_pkg::line_of(dc_wr_addr_q) == code_line;
    castout_line_d = slfc_pkg::line_of(dc_wr_addr_q);
  end

  // Store buffer registers; the cache write port is offered only for a
  // committed head entry.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sb_hib_q       <= '0;
      sb_cmt_q       <= '0;
      head_q         <= '0;
      tail_q         <= '0;
      cptr_q         <= '0;
      cnt_q          <= '0;
      st_ready_q     <= 1'b0;
      dc_wr_valid_q  <= 1'b0;
      dc_wr_addr_q   <= '0;
      dc_wr_sz_q     <= slfc_pkg::SZ_BYTE;
      dc_wr_data_q   <= '0;
      castout_q      <= 1'b0;
      castout_line_q <= '0;
    end else begin
      sb_addr_q      <= sb_addr_d;
      sb_sz_q        <= sb_sz_d;
      sb_data_q      <= sb_data_d;
      sb_hib_q       <= sb_hib_d;
      sb_cmt_q       <= sb_cmt_d;
      head_q         <= head_d;
      tail_q         <= tail_d;
      cptr_q         <= cptr_d;
      cnt_q          <= cnt_d;
      st_ready_q     <= cnt_d < (PW+1)'(SB_DEPTH);
      dc_wr_valid_q  <= cnt_d != '0 && sb_cmt_d[head_d];
      dc_wr_addr_q   <= sb_addr_d[head_d];
      dc_wr_sz_q     <= sb_sz_d[head_d];
      dc_wr_data_q   <= sb_data_d[head_d];
      castout_q      <= castout_d;
      castout_line_q <= castout_line_d;
    end
  end

  // ----------------------------------------------------------------------
  // Load check
  // ----------------------------------------------------------------------
  slfc_chk_if chk ();

  slfc_elig u_elig (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .chk     (chk.elig_side)
  );

  slfc_pkg::slfc_ld_state_t    st_q, st_d;
  logic [slfc_pkg::ADDR_W-1:0] la_q, la_d;
  slfc_pkg::slfc_size_t        ls_q, ls_d;
  logic [PW:0]                 wait_q, wait_d;
  logic                        done_d, fwd_d;
  logic [slfc_pkg::DATA_W-1:0] data_d;
  logic                        hit;
  logic [PW-1:0]               sel;
  logic [PW:0]                 pos;
  logic [PW-1:0]               idx;

  // Scan oldest to youngest so the last hit is the youngest older store.
  always_comb begin
    hit = 1'b0;
    sel = head_q;
    pos = '0;
    idx = head_q;
    for (int i = 0; i < SB_DEPTH; i++) begin
      idx = head_q + PW'(i);
      if ((PW+1)'(i) < cnt_q &&
          slfc_pkg::alias_overlap(la_q, ls_q, sb_addr_q[idx],
                                  sb_sz_q[idx])) begin
        hit = 1'b1;
        sel = idx;
        pos = (PW+1)'(i + 1);
      end
    end
    chk.ld_addr = la_q;
    chk.ld_sz   = ls_q;
    chk.st_addr = sb_addr_q[sel];
    chk.st_sz   = sb_sz_q[sel];
    chk.st_hib  = sb_hib_q[sel];
    chk.st_data = sb_data_q[sel];
  end

  // A hit that cannot forward, including a pure alias on the low bits, is
  // held until every store up to the blocker has drained to the cache.
  always_comb begin
    st_d   = st_q;
    la_d   = la_q;
    ls_d   = ls_q;
    wait_d = wait_q;
    done_d = 1'b0;
    fwd_d  = 1'b0;
    data_d = '0;
    unique case (st_q)
      slfc_pkg::LD_IDLE: begin
        if (ld_valid && ld_ready_q) begin
          la_d = ld_addr;
          ls_d = ld_sz;
          st_d = slfc_pkg::LD_CHECK;
        end
      end
      slfc_pkg::LD_CHECK: begin
        if (!hit) begin
          done_d = 1'b1;
          st_d   = slfc_pkg::LD_IDLE;
        end else if (chk.fwd_ok) begin
          done_d = 1'b1;
          fwd_d  = 1'b1;
          data_d = chk.fwd_data;
          st_d   = slfc_pkg::LD_IDLE;
        end else begin
          wait_d = pos - (PW+1)'(pop);
          if (wait_d == '0) begin
            done_d = 1'b1;
            st_d   = slfc_pkg::LD_IDLE;
          end else begin
            st_d = slfc_pkg::LD_HOLD;
          end
        end
      end
      slfc_pkg::LD_HOLD: begin
        wait_d = wait_q - (PW+1)'(pop);
        if (wait_d == '0) begin
          done_d = 1'b1;
          st_d   = slfc_pkg::LD_IDLE;
        end
      end
      default: begin
        st_d = slfc_pkg::LD_IDLE;
      end
    endcase
  end

  // Load registers and result outputs.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_q       <= slfc_pkg::LD_IDLE;
      la_q       <= '0;
      ls_q       <= slfc_pkg::SZ_BYTE;
      wait_q     <= '0;
      ld_ready_q <= 1'b0;
      ld_done_q  <= 1'b0;
      ld_fwd_q   <= 1'b0;
      ld_data_q  <= '0;
      ld_held_q  <= 1'b0;
    end else begin
      st_q       <= st_d;
      la_q       <= la_d;
      ls_q       <= ls_d;
      wait_q     <= wait_d;
      ld_ready_q <= st_d == slfc_pkg::LD_IDLE;
      ld_done_q  <= done_d;
      ld_fwd_q   <= fwd_d;
      ld_data_q  <= data_d;
      ld_held_q  <= st_d == slfc_pkg::LD_HOLD;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_load_taken;
    ld_valid && ld_ready_q;
  endsequence
  sequence s_load_resolved;
    ld_done_q || ld_held_q;
  endsequence

  a_load_resolve: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_load_taken |-> ##2 s_load_resolved)
    else $error("Load neither finished nor held two cycles after issue.");
  a_held_no_done: assert property (@(posedge sys_clk) disable iff (!nrst)
    ld_held_q && wait_q > (PW+1)'(1) |=> !ld_done_q)
    else $error("Held load finished before its blocking store drained.");
  a_held_fwd: assert property (@(posedge sys_clk) disable iff (!nrst)
    ld_held_q ##1 ld_done_q |-> !ld_fwd_q)
    else $error("Held load took forwarded data.");
  a_write_commit: assert property (@(posedge sys_clk) disable iff (!nrst)
    dc_wr_valid_q |-> sb_cmt_q[head_q] && cnt_q != '0)
    else $error("Cache write offered for an unretired store.");
  a_castout_line: assert property (@(posedge sys_clk) disable iff (!nrst)
    pop && code_line_valid && slfc_pkg::line_of(dc_wr_addr_q) == code_line
    |=> castout_q && castout_line_q == $past(code_line))
    else $error("Shared code and data line was not cast out.");
  a_fwd_misal: assert property (@(posedge sys_clk) disable iff (!nrst)
    st_q == slfc_pkg::LD_CHECK && slfc_pkg::misaligned(la_q, ls_q)
    |=> !ld_fwd_q)
    else $error("Misaligned load received forwarded data.");
  a_partial_block: assert property (@(posedge sys_clk) disable iff (!nrst)
    st_q == slfc_pkg::LD_CHECK && hit && chk.st_addr != la_q
    |=> !ld_fwd_q)
    else $error("Store at another start address forwarded.");
  a_narrow_block: assert property (@(posedge sys_clk) disable iff (!nrst)
    st_q == slfc_pkg::LD_CHECK && hit && chk.st_sz < ls_q
    |=> !ld_fwd_q)
    else $error("Narrow store forwarded to a wider load.");

endmodule

// ===== verif/slfc_dcache_model.sv
// Data cache model that takes store buffer writes, promptly or slowly.
`timescale 1ns/1ps
module slfc_dcache_model (
  input  wire logic sys_clk,        // Core clock.
  input  wire logic nrst,           // Synchronous reset, active low.
  input  wire logic slow,           // Stall each write for a while.
  input  wire logic dc_wr_valid_q,  // Write offered by the buffer.
  output logic      dc_wr_ack       // Write taken this cycle.
);
  // ------------------------------------------------------------------
  // Acceptance
  // ------------------------------------------------------------------
  logic [1:0] wait_q;
  logic [1:0] wait_d;
  logic       ack_d;

  // Never acks two cycles running, so each write is judged afresh.
  always_comb begin
    wait_d = 2'h0;
    ack_d  = 1'b0;
    if (dc_wr_valid_q && !dc_wr_ack) begin
      if (!slow || wait_q == 2'h3) begin
        ack_d = 1'b1;
      end else begin
        wait_d = wait_q + 2'h1;
      end
    end
  end

  // Registered, so the ack only moves just after an edge.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wait_q    <= 2'h0;
      dc_wr_ack <= 1'b0;
    end else begin
      wait_q    <= wait_d;
      dc_wr_ack <= ack_d;
    end
  end
endmodule

// ===== verif/test_store_load_forward_check.sv
// Self-checking bench for the store-to-load forward check.
`timescale 1ns/1ps
module test_store_load_forward_check;
  // ------------------------------------------------------------------
  // Signals and bookkeeping
  // ------------------------------------------------------------------
  logic                 sys_clk, nrst, st_valid, st_hib, st_ready_q;
  logic                 rob_st_retire, dc_wr_valid_q, dc_wr_ack, slow;
  logic                 code_line_valid, castout_q, ld_valid, ld_ready_q;
  logic                 ld_done_q, ld_fwd_q, ld_held_q;
  logic [31:0]          st_addr, dc_wr_addr_q, ld_addr, lfsr;
  logic [63:0]          st_data, dc_wr_data_q, ld_data_q, sd;
  logic [25:0]          code_line, castout_line_q;
  slfc_pkg::slfc_size_t st_sz, dc_wr_sz_q, ld_sz;
  int                   miscompares, compares, acks, retires, pend;
  int                   n_ld, dones, co_exp, co_seen;
  logic                 fq[$];
  logic [63:0]          dq[$];
  int                   aq[$];
  logic [31:0]          wa[$];
  slfc_pkg::slfc_size_t ws[$];
  logic [63:0]          wd[$];

  slfc_fwd_top #(.SB_DEPTH(4)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .st_valid(st_valid),
    .st_addr(st_addr), .st_sz(st_sz), .st_data(st_data),
    .st_hib(st_hib), .st_ready_q(st_ready_q),
    .rob_st_retire(rob_st_retire), .dc_wr_valid_q(dc_wr_valid_q),
    .dc_wr_addr_q(dc_wr_addr_q), .dc_wr_sz_q(dc_wr_sz_q),
    .dc_wr_data_q(dc_wr_data_q), .dc_wr_ack(dc_wr_ack),
    .code_line_valid(code_line_valid), .code_line(code_line),
    .castout_q(castout_q), .castout_line_q(castout_line_q),
    .ld_valid(ld_valid), .ld_addr(ld_addr), .ld_sz(ld_sz),
    .ld_ready_q(ld_ready_q), .ld_done_q(ld_done_q),
    .ld_fwd_q(ld_fwd_q), .ld_data_q(ld_data_q), .ld_held_q(ld_held_q));

  slfc_dcache_model cache (
    .sys_clk(sys_clk), .nrst(nrst), .slow(slow),
    .dc_wr_valid_q(dc_wr_valid_q), .dc_wr_ack(dc_wr_ack));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Low bytes that a load of the given size keeps.
  function automatic logic [63:0] wmask(input slfc_pkg::slfc_size_t s);
    wmask = (s == slfc_pkg::SZ_QWORD) ? 64'hFFFF_FFFF_FFFF_FFFF :
            (64'h1 << (8 << s)) - 64'h1;
  endfunction

  task automatic check(input logic ok, input string msg);
    compares++;
    if (!ok) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Offers one store with random data and notes its cache write.
  task automatic push_store(input logic [31:0] a,
                            input slfc_pkg::slfc_size_t s, input logic h);
    lfsr = lfsr_next(lfsr);
    sd[63:32] = lfsr;
    lfsr = lfsr_next(lfsr);
    sd[31:0] = lfsr;
    st_valid <= 1'b1;
    st_addr <= a;
    st_sz <= s;
    st_hib <= h;
    st_data <= sd;
    slow <= lfsr[3];
    wa.push_back(a);
    ws.push_back(s);
    wd.push_back(sd);
    if (code_line_valid && a[31:6] == code_line) co_exp++;
    @(posedge sys_clk);
    while (!st_ready_q) @(posedge sys_clk);
    st_valid <= 1'b0;
    pend++;
  endtask

  // Issues a load, notes its result and checks the held flag.
  task automatic issue_load(input logic [31:0] a,
                            input slfc_pkg::slfc_size_t s,
                            input logic fw, input logic hold, input int nb);
    ld_valid <= 1'b1;
    ld_addr <= a;
    ld_sz <= s;
    fq.push_back(fw);
    dq.push_back(fw ? (sd & wmask(s)) : 64'h0);
    aq.push_back(acks + (hold ? nb : 0));
    @(posedge sys_clk);
    while (!ld_ready_q) @(posedge sys_clk);
    ld_valid <= 1'b0;
    n_ld++;
    repeat (2) @(posedge sys_clk);
    #1;
    check(ld_held_q === hold, "load held flag wrong");
  endtask

  // Retires every buffered store, then waits for load and writes.
  task automatic drain;
    int i;
    @(posedge sys_clk);
    while (pend > 0) begin
      rob_st_retire <= 1'b1;
      pend--;
      @(posedge sys_clk);
    end
    rob_st_retire <= 1'b0;
    for (i = 0; i < 200 && (dones < n_ld || wa.size() > 0); i++) begin
      @(posedge sys_clk);
    end
    check(dones == n_ld && wa.size() == 0, "case did not complete");
  endtask

  task automatic run_case(input logic [31:0] sa,
                          input slfc_pkg::slfc_size_t ss, input logic h,
                          input logic [31:0] la,
                          input slfc_pkg::slfc_size_t ls,
                          input logic fw, input logic hold);
    push_store(sa, ss, h);
    issue_load(la, ls, fw, hold, 1);
    drain;
  endtask

  // ------------------------------------------------------------------
  // Clock, watchdog and result monitor
  // ------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // The whole run needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    end_sim;
  end

  // Takes the oldest note whenever a load result or cache write shows.
  always @(posedge sys_clk) begin
    if (nrst) begin
      if (rob_st_retire) retires++;
      if (dc_wr_valid_q) begin
        check(acks < retires, "write before retire");
      end
      if (dc_wr_valid_q && dc_wr_ack) begin
        acks++;
        check(wa.size() > 0 && dc_wr_addr_q === wa[0] &&
              dc_wr_sz_q === ws[0] && dc_wr_data_q === wd[0],
              "cache write wrong");
        void'(wa.pop_front());
        void'(ws.pop_front());
        void'(wd.pop_front());
      end
      if (ld_done_q) begin
        check(fq.size() > 0 && ld_fwd_q === fq[0] &&
              ld_data_q === dq[0], "load result wrong");
        check(acks >= aq[0], "held load done too early");
        void'(fq.pop_front());
        void'(dq.pop_front());
        void'(aq.pop_front());
        dones++;
      end
      if (castout_q) begin
        co_seen++;
        check(castout_line_q === code_line,
              "castout line wrong");
      end
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {nrst, st_valid, st_hib, rob_st_retire, ld_valid, slow} = 6'h0;
    {st_addr, ld_addr, st_data, sd} = 192'h0;
    st_sz = slfc_pkg::SZ_BYTE;
    ld_sz = slfc_pkg::SZ_BYTE;
    code_line_valid = 1'b1;
    code_line = 26'h00000C1;
    lfsr = 32'h3F15_BB5C;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check(st_ready_q === 1'b1 && ld_ready_q === 1'b1, "not ready");
    @(posedge sys_clk);
    for (int s = 0; s < 4; s++) begin
      run_case(32'h100, slfc_pkg::slfc_size_t'(s), 1'b0, 32'h100,
               slfc_pkg::slfc_size_t'(s), 1'b1, 1'b0);
    end
    run_case(32'h108, slfc_pkg::SZ_QWORD, 1'b0, 32'h108,
             slfc_pkg::SZ_DWORD, 1'b1, 1'b0);
    run_case(32'h110, slfc_pkg::SZ_DWORD, 1'b0, 32'h110,
             slfc_pkg::SZ_WORD, 1'b0, 1'b1);
    run_case(32'h10, slfc_pkg::SZ_WORD, 1'b0, 32'h10,
             slfc_pkg::SZ_DWORD, 1'b0, 1'b1);
    run_case(32'h13, slfc_pkg::SZ_BYTE, 1'b0, 32'h10,
             slfc_pkg::SZ_DWORD, 1'b0, 1'b1);
    run_case(32'h10, slfc_pkg::SZ_DWORD, 1'b0, 32'h12,
             slfc_pkg::SZ_WORD, 1'b0, 1'b1);
    run_case(32'h24, slfc_pkg::SZ_QWORD, 1'b0, 32'h24,
             slfc_pkg::SZ_QWORD, 1'b0, 1'b1);
    run_case(32'h21, slfc_pkg::SZ_WORD, 1'b0, 32'h21,
             slfc_pkg::SZ_WORD, 1'b0, 1'b1);
    run_case(32'h10, slfc_pkg::SZ_BYTE, 1'b1, 32'h10,
             slfc_pkg::SZ_BYTE, 1'b0, 1'b1);
    run_case(32'h1010, slfc_pkg::SZ_DWORD, 1'b0, 32'h2010,
             slfc_pkg::SZ_DWORD, 1'b0, 1'b1);
    run_case(32'h3040, slfc_pkg::SZ_DWORD, 1'b0, 32'h200,
             slfc_pkg::SZ_DWORD, 1'b0, 1'b0);
    run_case(32'h3080, slfc_pkg::SZ_DWORD, 1'b0, 32'h3080,
             slfc_pkg::SZ_DWORD, 1'b1, 1'b0);
    // A write into the code line must not cast out once no code is there.
    code_line_valid <= 1'b0;
    @(posedge sys_clk);
    run_case(32'h3048, slfc_pkg::SZ_DWORD, 1'b0, 32'h3048,
             slfc_pkg::SZ_DWORD, 1'b1, 1'b0);
    push_store(32'h140, slfc_pkg::SZ_QWORD, 1'b0);
    @(posedge sys_clk);
    push_store(32'h140, slfc_pkg::SZ_DWORD, 1'b0);
    issue_load(32'h140, slfc_pkg::SZ_DWORD, 1'b1, 1'b0, 2);
    drain;
    push_store(32'h150, slfc_pkg::SZ_DWORD, 1'b0);
    @(posedge sys_clk);
    push_store(32'h153, slfc_pkg::SZ_BYTE, 1'b0);
    issue_load(32'h150, slfc_pkg::SZ_DWORD, 1'b0, 1'b1, 2);
    drain;
    check(co_seen == co_exp, "castout count wrong");
    end_sim;
  end
endmodule
